/* File: rtl/dofc_map.svh */
// Register offsets, field positions, reset values and timing counts for the output control block.
// Assumes a 32-bit APB bus on a 200 MHz clock.
`ifndef DOFC_MAP_SVH
`define DOFC_MAP_SVH

// Register byte offsets
`define DOFC_EXT_CFG_OFS 12'h000
`define DOFC_INT_CFG_OFS 12'h004
`define DOFC_PIN2_CFG_OFS 12'h008
`define DOFC_PIN3_CFG_OFS 12'h00C
`define DOFC_FAULT_OFS 12'h010
`define DOFC_STATE_OFS 12'h014

// Output configuration fields (same layout for external and internal)
`define DOFC_MODE_LSB 0
`define DOFC_MODE_W 3
`define DOFC_SRC_BIT 3
`define DOFC_T1_LSB 4
`define DOFC_T2_LSB 8
`define DOFC_TIME_W 4
`define DOFC_DATA_BIT 12
`define DOFC_CFG_MASK 32'h0000_1FFF
`define DOFC_CFG_RESET 32'h0000_0000

// Pin configuration code that hands the output to the pin
`define DOFC_PIN_DRIVE_CODE 32'h0000_0004
`define DOFC_PIN_RESET 32'h0000_0000

// Fault status bits
`define DOFC_F_EXT_SC 0
`define DOFC_F_INT_SC 1
`define DOFC_F_EXT_TO 2
`define DOFC_F_INT_TO 3
`define DOFC_F_THERM 4
`define DOFC_FAULT_W 5

// Timer unit: one code step is 10 us
`define DOFC_TIME_UNIT_NS 10000
`define DOFC_CLK_PERIOD_NS 5
`define DOFC_UNIT_CYCLES (`DOFC_TIME_UNIT_NS / `DOFC_CLK_PERIOD_NS)

`endif

/* File: rtl/dofc_pkg.sv */
// Types shared by the output control block.
// Assumes the map header supplies the register numbers; the mode codes and widths are set here.
package dofc_pkg;

	typedef enum logic [2:0] {
		DOFC_M_OFF = 3'h0,
		DOFC_M_SRC = 3'h1,
		DOFC_M_SNK = 3'h2,
		DOFC_M_PP = 3'h3,
		DOFC_M_SRC_DIODE = 3'h4
	} dofc_mode_t;

	typedef enum logic [1:0] {
		DOFC_SC_IDLE,
		DOFC_SC_T1,
		DOFC_SC_WAIT,
		DOFC_SC_T2
	} dofc_sc_t;

endpackage

/* File: rtl/dofc_top.sv */
// Digital output FET control with APB registers, short-circuit timers and thermal shutdown of the internal stage.
// Assumes detector and pin inputs are asynchronous and the APB master is on pclk.
`timescale 1ns/100ps
`include "dofc_map.svh"

module dofc_top (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins and analog detectors
	input wire logic gpio_b,
	input wire logic gpio_c,
	input wire logic ext_sc_det,
	input wire logic int_sc_det,
	input wire logic over_temp,
	// External FET stage
	output logic ext_pfet_gate,
	output logic ext_nfet_gate,
	output logic smart_diode_gate,
	output logic ext_high_limit,
	// Internal FET stage
	output logic int_src_fet,
	output logic int_snk_fet,
	output logic int_high_limit,
	// Fault notice, active low
	output logic alert_n
);

	logic [12:0] ext_output_cfg_r;
	logic [12:0] int_output_cfg_r;
	logic [31:0] second_pin_cfg_r;
	logic [31:0] third_pin_cfg_r;
	logic [`DOFC_FAULT_W-1:0] fault_r;
	logic [4:0] s1_r;
	logic [4:0] s2_r;
	logic wr_en;
	logic rd_en;
	logic ext_on;
	logic int_on;
	logic ext_to;
	logic int_to;
	logic ext_sc_ev;
	logic int_sc_ev;
	logic ext_hi;
	logic int_hi;
	logic therm_off_r;
	logic ext_drive;
	logic int_drive;
	logic [4:0] clr;

	function automatic logic [15:0] dofc_cycles(input logic [3:0] code);
		dofc_cycles = 16'(code) * 16'(`DOFC_UNIT_CYCLES);
	endfunction

	// Detector and pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= 5'h00;
			s2_r <= 5'h00;
		end else begin
			s1_r <= {over_temp, int_sc_det, ext_sc_det, gpio_c, gpio_b};
			s2_r <= s1_r;
		end
	end

	// APB slave, zero wait states
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign pslverr = psel && penable && (paddr > `DOFC_STATE_OFS || paddr[1:0] != 2'b00);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			second_pin_cfg_r <= `DOFC_PIN_RESET;
			third_pin_cfg_r <= `DOFC_PIN_RESET;
		end else if (wr_en) begin
			if (paddr == `DOFC_PIN2_CFG_OFS) second_pin_cfg_r <= pwdata;
			if (paddr == `DOFC_PIN3_CFG_OFS) third_pin_cfg_r <= pwdata;
		end
	end

	// Timeout forces mode to disabled; a host write in the same cycle loses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_output_cfg_r <= 13'(`DOFC_CFG_RESET);
		end else if (ext_to) begin
			ext_output_cfg_r[2:0] <= dofc_pkg::DOFC_M_OFF;
		end else if (wr_en && paddr == `DOFC_EXT_CFG_OFS) begin
			ext_output_cfg_r <= pwdata[12:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_output_cfg_r <= 13'(`DOFC_CFG_RESET);
		end else if (int_to) begin
			int_output_cfg_r[2:0] <= dofc_pkg::DOFC_M_OFF;
		end else if (wr_en && paddr == `DOFC_INT_CFG_OFS) begin
			int_output_cfg_r <= pwdata[12:0];
		end
	end

	// Output data selection
	always_comb begin
		if (ext_output_cfg_r[`DOFC_SRC_BIT] && second_pin_cfg_r == `DOFC_PIN_DRIVE_CODE)
			ext_drive = s2_r[0];
		else
			ext_drive = ext_output_cfg_r[`DOFC_DATA_BIT];
		if (int_output_cfg_r[`DOFC_SRC_BIT] && third_pin_cfg_r == `DOFC_PIN_DRIVE_CODE)
			int_drive = s2_r[1];
		else
			int_drive = int_output_cfg_r[`DOFC_DATA_BIT];
	end

	// Gate decode per mode
	always_comb begin
		ext_pfet_gate = 1'b0;
		ext_nfet_gate = 1'b0;
		smart_diode_gate = 1'b0;
		unique case (ext_output_cfg_r[2:0])
			dofc_pkg::DOFC_M_SRC: ext_pfet_gate = ext_drive;
			dofc_pkg::DOFC_M_SNK: ext_nfet_gate = ext_drive;
			dofc_pkg::DOFC_M_PP: begin
				ext_pfet_gate = ext_drive;
				ext_nfet_gate = !ext_drive;
			end
			dofc_pkg::DOFC_M_SRC_DIODE: begin
				ext_pfet_gate = ext_drive;
				smart_diode_gate = ext_drive;
			end
			default: ;
		endcase
		int_src_fet = 1'b0;
		int_snk_fet = 1'b0;
		if (!therm_off_r) begin
			unique case (int_output_cfg_r[2:0])
				dofc_pkg::DOFC_M_SRC: int_src_fet = int_drive;
				dofc_pkg::DOFC_M_SNK: int_snk_fet = int_drive;
				dofc_pkg::DOFC_M_PP: begin
					int_src_fet = int_drive;
					int_snk_fet = !int_drive;
				end
				default: ;
			endcase
		end
	end

	assign ext_on = ext_pfet_gate || ext_nfet_gate;
	assign int_on = int_src_fet || int_snk_fet;
	assign ext_high_limit = ext_hi;
	assign int_high_limit = int_hi;

	// Thermal shutdown of the internal stage with automatic retry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			therm_off_r <= 1'b0;
		else if (int_output_cfg_r[2:0] == dofc_pkg::DOFC_M_OFF)
			therm_off_r <= 1'b0;
		else
			therm_off_r <= s2_r[4];
	end

	// Short-circuit timers, one per stage
	for (genvar g = 0; g < 2; g++) begin : g_sc
		dofc_pkg::dofc_sc_t st_r;
		logic [15:0] cnt_r;
		logic on;
		logic sc;
		logic pp;
		logic on_d_r;
		logic [3:0] t1;
		logic [3:0] t2;
		logic to_ev;
		logic sc_ev;
		assign on = (g == 0) ? ext_on : int_on;
		assign sc = s2_r[2 + g];
		assign pp = ((g == 0) ? ext_output_cfg_r[2:0] : int_output_cfg_r[2:0]) == dofc_pkg::DOFC_M_PP;
		assign t1 = (g == 0) ? ext_output_cfg_r[7:4] : int_output_cfg_r[7:4];
		assign t2 = (g == 0) ? ext_output_cfg_r[11:8] : int_output_cfg_r[11:8];
		assign sc_ev = on && sc && st_r != dofc_pkg::DOFC_SC_T1;
		assign to_ev = st_r == dofc_pkg::DOFC_SC_T2 && cnt_r == 16'h0000 && sc;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				st_r <= dofc_pkg::DOFC_SC_IDLE;
				cnt_r <= 16'h0000;
				on_d_r <= 1'b0;
			end else begin
				on_d_r <= on;
				if (!on) begin
					st_r <= dofc_pkg::DOFC_SC_IDLE;
					cnt_r <= 16'h0000;
				end else unique case (st_r)
					dofc_pkg::DOFC_SC_IDLE: if (!on_d_r && t1 != 4'h0 && !pp) begin
						st_r <= dofc_pkg::DOFC_SC_T1;
						cnt_r <= dofc_cycles(t1) - 16'h0001;
					end else begin
						st_r <= dofc_pkg::DOFC_SC_WAIT;
					end
					dofc_pkg::DOFC_SC_T1: if (cnt_r == 16'h0000)
						st_r <= dofc_pkg::DOFC_SC_WAIT;
					else
						cnt_r <= cnt_r - 16'h0001;
					dofc_pkg::DOFC_SC_WAIT: if (sc) begin
						st_r <= dofc_pkg::DOFC_SC_T2;
						cnt_r <= dofc_cycles(t2);
					end
					dofc_pkg::DOFC_SC_T2: if (cnt_r == 16'h0000)
						st_r <= dofc_pkg::DOFC_SC_IDLE;
					else if (!sc)
						st_r <= dofc_pkg::DOFC_SC_WAIT;
					else
						cnt_r <= cnt_r - 16'h0001;
				endcase
			end
		end
		if (g == 0) begin : g_e
			assign ext_to = to_ev;
			assign ext_sc_ev = sc_ev;
			assign ext_hi = st_r == dofc_pkg::DOFC_SC_T1;
		end else begin : g_i
			assign int_to = to_ev;
			assign int_sc_ev = sc_ev;
			assign int_hi = st_r == dofc_pkg::DOFC_SC_T1;
		end
	end

	// Sticky fault flags, write one to clear, set wins
	assign clr = (wr_en && paddr == `DOFC_FAULT_OFS) ? pwdata[4:0] : 5'h00;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fault_r <= 5'h00;
		else
			fault_r <= (fault_r & ~clr) | {s2_r[4] && int_output_cfg_r[2:0] != 3'h0,
				int_to, ext_to, int_sc_ev, ext_sc_ev};
	end
	assign alert_n = !(|fault_r);

	// Read data registered in setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_en) begin
			unique case (paddr)
				`DOFC_EXT_CFG_OFS: prdata <= {19'h0, ext_output_cfg_r};
				`DOFC_INT_CFG_OFS: prdata <= {19'h0, int_output_cfg_r};
				`DOFC_PIN2_CFG_OFS: prdata <= second_pin_cfg_r;
				`DOFC_PIN3_CFG_OFS: prdata <= third_pin_cfg_r;
				`DOFC_FAULT_OFS: prdata <= {27'h0, fault_r};
				`DOFC_STATE_OFS: prdata <= {24'h0, int_hi, ext_hi, therm_off_r, s2_r[4:0]};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	chk_timeout_clears_mode: assert property (@(posedge pclk) disable iff (!presetn)
		ext_to |=> ext_output_cfg_r[2:0] == 3'h0 && !ext_pfet_gate && fault_r[2])
		else $error("external timeout did not disable output");
	chk_no_t1_pushpull: assert property (@(posedge pclk) disable iff (!presetn)
		ext_output_cfg_r[2:0] == 3'h3 && $past(ext_output_cfg_r[2:0]) == 3'h3 |-> !ext_hi)
		else $error("high limit in push-pull");
	chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		fault_r[0] && !clr[0] |=> fault_r[0])
		else $error("fault flag dropped without clear");
	chk_alert_follows: assert property (@(posedge pclk) disable iff (!presetn)
		ext_sc_ev |=> !alert_n)
		else $error("alert not raised on short");
	chk_therm_off: assert property (@(posedge pclk) disable iff (!presetn)
		therm_off_r |-> !int_src_fet && !int_snk_fet)
		else $error("internal FET on during shutdown");
	chk_diode_gate: assert property (@(posedge pclk) disable iff (!presetn)
		smart_diode_gate |-> ext_pfet_gate && ext_output_cfg_r[2:0] == 3'h4)
		else $error("smart diode gate wrong");
	chk_t1_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		ext_hi && !fault_r[0] |=> !fault_r[0])
		else $error("alert during high-limit window");
	chk_pp_both: assert property (@(posedge pclk) disable iff (!presetn)
		int_output_cfg_r[2:0] == 3'h3 && !therm_off_r |-> int_src_fet != int_snk_fet)
		else $error("push-pull FETs not complementary");

endmodule

/* File: dv/dofc_load.sv */
// Load model: FET stages with short-circuit and heat detectors.
// Assumes the bench raises fault requests and the block drives the gates.
`timescale 1ns/100ps
module dofc_load #(parameter int LAG = 2) (
	// Clock
	input wire logic pclk,
	// Gates seen by the load
	input wire logic ext_on,
	input wire logic int_on,
	// Fault requests from the bench
	input wire logic short_req,
	input wire logic heat_req,
	// Detector outputs
	output logic ext_sc_det,
	output logic int_sc_det,
	output logic over_temp
);
	logic [3:0] ext_d = 4'h0;
	logic [3:0] int_d = 4'h0;
	// A short only draws current while its stage conducts
	always @(posedge pclk) begin
		ext_d <= {ext_d[2:0], short_req & ext_on};
		int_d <= {int_d[2:0], short_req & int_on};
	end
	assign ext_sc_det = ext_d[LAG-1];
	assign int_sc_det = int_d[LAG-1];
	assign over_temp = heat_req;
endmodule

/* File: dv/dofc_top_test.sv */
// Directed bench for the output control block over APB.
// Assumes dofc_load stands for the FET stages and their detectors.
`timescale 1ns/100ps
`include "dofc_map.svh"
module dofc_top_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic gpio_b = 1'b0;
	logic gpio_c = 1'b0;
	logic short_req = 1'b0;
	logic heat_req = 1'b0;
	logic [31:0] prdata, q;
	logic pready, pslverr, slv, ext_sc_det, int_sc_det, over_temp;
	wire [7:0] g;
	logic [1:0] on_v, hi_v;
	int bad_count = 0;
	int checked = 0;
	assign on_v = {g[3], g[7]};
	assign hi_v = {g[1], g[4]};
	always #2.5 pclk = ~pclk;
	dofc_top i_dofc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gpio_b(gpio_b), .gpio_c(gpio_c), .ext_sc_det(ext_sc_det),
		.int_sc_det(int_sc_det), .over_temp(over_temp), .ext_pfet_gate(g[7]),
		.ext_nfet_gate(g[6]), .smart_diode_gate(g[5]), .ext_high_limit(g[4]),
		.int_src_fet(g[3]), .int_snk_fet(g[2]), .int_high_limit(g[1]), .alert_n(g[0]));
	dofc_load i_dofc_load (.pclk(pclk), .ext_on(g[7] | g[6]), .int_on(g[3] | g[2]),
		.short_req(short_req), .heat_req(heat_req), .ext_sc_det(ext_sc_det),
		.int_sc_det(int_sc_det), .over_temp(over_temp));
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [31:0] cw(input int m, input logic s, input logic [3:0] t,
		input logic d);
		return {19'h0, d, t, t, s, 3'(m)};
	endfunction
	// Configure first, then set the data bit in a separate write
	task automatic turn_on(input int k, input int m, input logic [3:0] t);
		apb(1'b1, 12'(4 * k), cw(m, 1'b0, t, 1'b0));
		apb(1'b1, 12'(4 * k), cw(m, 1'b0, t, 1'b1));
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int a = 0; a < 7; a++) begin
			apb(1'b0, 12'(4 * a), 32'h0);
			chk("reset read", 32'h0, q);
			chk("slverr", 32'(a == 6), 32'(slv));
		end
		$display("test reset done");
		for (int k = 0; k < 2; k++) begin
			for (int m = 1; m < 5 - k; m++) begin
				for (int d = 0; d < 2; d++) begin
					apb(1'b1, 12'(4 * k), cw(m, 1'b0, 4'h1, d[0]));
					@(posedge pclk);
					chk("mode gates", {28'h0, d[0] & (m != 2), (m == 2 & d[0]) | (m == 3 & !d[0]),
						k == 0 & m == 4 & d[0], d[0] & (m != 3)}, k == 0 ? 32'(g[7:4]) :
						{28'h0, g[3], g[2], 1'b0, g[1]});
				end
				apb(1'b1, 12'(4 * k), 32'h0);
			end
		end
		$display("test modes done");
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, 12'(8 + 4 * k), `DOFC_PIN_DRIVE_CODE);
			apb(1'b1, 12'(4 * k), cw(1, 1'b1, 4'h0, 1'b0));
			for (int d = 1; d >= 0; d--) begin
				gpio_b <= d[0];
				gpio_c <= d[0];
				repeat (4) @(posedge pclk);
				chk("pin drive", 32'(d), 32'(on_v[k]));
			end
			apb(1'b1, 12'(4 * k), 32'h0);
		end
		$display("test pins done");
		for (int k = 0; k < 2; k++) begin
			turn_on(k, 1, 4'h1);
			short_req <= 1'b1;
			repeat (1000) @(posedge pclk);
			chk("T1 hold", 32'h7, {29'h0, on_v[k], hi_v[k], g[0]});
			repeat (1100) @(posedge pclk);
			chk("T2 run", 32'h4, {29'h0, on_v[k], hi_v[k], g[0]});
			apb(1'b0, `DOFC_FAULT_OFS, 32'h0);
			chk("short flag", 32'(1 << k), q);
			repeat (2000) @(posedge pclk);
			short_req <= 1'b0;
			chk("timeout off", 32'h0, 32'(on_v[k]));
			apb(1'b0, `DOFC_FAULT_OFS, 32'h0);
			chk("timeout flag", 32'(5 << k), q);
			apb(1'b0, 12'(4 * k), 32'h0);
			chk("mode cleared", 32'h0, 32'(q[2:0]));
			apb(1'b1, `DOFC_FAULT_OFS, 32'(1 << k));
			apb(1'b0, `DOFC_FAULT_OFS, 32'h0);
			chk("one cleared", 32'(4 << k), q);
			apb(1'b1, `DOFC_FAULT_OFS, 32'(4 << k));
			apb(1'b1, 12'(4 * k), 32'h0);
			turn_on(k, 1, 4'h0);
			chk("recovered", 32'h5, {29'h0, on_v[k], hi_v[k], g[0]});
			apb(1'b1, 12'(4 * k), 32'h0);
		end
		$display("test short done");
		turn_on(1, 1, 4'h0);
		heat_req <= 1'b1;
		repeat (5) @(posedge pclk);
		chk("thermal off", 32'h0, 32'(g[3]));
		apb(1'b0, `DOFC_FAULT_OFS, 32'h0);
		chk("thermal flag", 32'h10, q);
		heat_req <= 1'b0;
		repeat (5) @(posedge pclk);
		chk("thermal back", 32'h1, 32'(g[3]));
		$display("test thermal done");
		conclude();
	end
endmodule
